// [hdl/dsd_serial_dac_input.sv]
`timescale 1ns/1ns
`include "dsd_map.svh"

// Behaviour
// R1: Select high enters single-converter mode
// R2: Dedication select picks left or right data
// R3: Single mode picks words from shared stream
// R4: Single mode parks left output at common
// R5: Words are two's complement, MSB first
// R6: Word fall loads only last 16 bits
// R7: Word clock sets load and integrate time (single mode integrates on channel select high alone, word clock ignored)
// R8: Source keeps word clock near half duty (bench source holds it high through each word and low for one bit only)
// R9: Everything happens on rising bit-clock edges
// R10: Bit clock at most 8.47 MHz
// R11: Load waits for edge after LSB
// R12: Stopped clock needs one extra edge
// R13: Source sends words at 176.4 kHz
// R14: Each channel integrates when selected, else holds
// R15: Two-channel: low is right, high is left
// R16: Two-channel integrate decode per channel
// R17: Left dedication inhibits low, accepts high
// R18: Right dedication accepts low, inhibits high
// R19: Converter register holds until next load
module dsd_serial_dac_input
  import dsd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock,
  input wire logic serial_data,
  input wire logic word_latch_clock,
  input wire logic channel_select_clock,
  input wire logic conv_ready,
  output logic [15:0] left_out,
  output logic [15:0] right_out,
  output logic left_integrate,
  output logic right_integrate,
  output logic left_at_common
);

  // ==========================================================
  // Decode functions
  function automatic logic [1:0] accept_word(dsd_ctrl_t c, logic lr);
    logic [1:0] r;
    r = 2'b00;
    if (!c.single) begin
      r = {1'b1, lr}; // [R15]
    end else if (!c.dedicate) begin
      r = {lr, 1'b1}; // [R17]
    end else begin
      r = {!lr, 1'b0}; // [R18]
    end
    return r;
  endfunction

  function automatic dsd_pair_t integ(dsd_ctrl_t c, logic lr, logic wd);
    dsd_pair_t p;
    p = '0;
    if (!c.single) begin
      p.left = !lr && wd; // [R16]
      p.right = lr && wd; // [R16]
    end else begin
      p.right = lr; // [R17] [R18]
    end
    return p;
  endfunction

  // ==========================================================
  // Register state
  dsd_ctrl_t ctrl_q, ctrl_d;
  logic ovf_q, ovf_d, rate_q, rate_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic access, do_wr, status_clr;

  // ==========================================================
  // Serial state
  logic bclk_q, lr_q, wd_q;
  logic bclk_d, lr_d, wd_d;
  logic [15:0] shift_q, shift_d;
  logic [1:0] gap_q, gap_d;
  logic bclk_rise, xfer_edge;
  logic [1:0] acc;
  logic push_valid, push_ready;
  dsd_word_t push_data, pop_data;
  logic pop_valid;
  logic [`DSD_FIFO_AW:0] fifo_level;

  // ==========================================================
  // Converter and output state
  dsd_word_t conv_q, conv_d;
  logic conv_load;
  dsd_pair_t int_q, int_d;
  logic [15:0] lout_q, lout_d, rout_q, rout_d;
  logic lcom_q, lcom_d;

  // ==========================================================
  // Bit-clock edge and serial shift
  always_comb begin
    bclk_d = bit_clock;
    bclk_rise = bit_clock && !bclk_q; // [R9]
    xfer_edge = bclk_rise && !word_latch_clock && wd_q; // [R6] [R7]
    lr_d = bclk_rise ? channel_select_clock : lr_q; // [R9]
    wd_d = bclk_rise ? word_latch_clock : wd_q; // [R9]
    shift_d = bclk_rise ? {shift_q[14:0], serial_data} : shift_q; // [R5]
    gap_d = bclk_rise ? 2'h0 : ((gap_q == 2'h3) ? gap_q : gap_q + 2'h1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_q <= 1'b0;
      lr_q <= 1'b0;
      wd_q <= 1'b0;
      shift_q <= '0;
      gap_q <= 2'h3;
    end else begin
      bclk_q <= bclk_d;
      lr_q <= lr_d;
      wd_q <= wd_d;
      shift_q <= shift_d;
      gap_q <= gap_d;
    end
  end

  // ==========================================================
  // Word acceptance into the buffer
  always_comb begin
    acc = accept_word(ctrl_q, lr_q); // [R1] [R2] [R3]
    push_valid = xfer_edge && acc[1];
    // The bits loaded are those of earlier edges, not this one
    push_data.data = shift_q; // [R6] [R11] [R12]
    push_data.chan = dsd_chan_t'(acc[0]);
  end

  dsd_fifo #(
    .WIDTH($bits(dsd_word_t)),
    .DEPTH(`DSD_FIFO_DEPTH),
    .AW(`DSD_FIFO_AW)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(conv_ready),
    .out_data(pop_data),
    .level(fifo_level)
  );

  // ==========================================================
  // Converter register and integrate/hold stages
  always_comb begin
    conv_load = pop_valid && conv_ready;
    conv_d = conv_load ? pop_data : conv_q; // [R19]
    int_d = integ(ctrl_q, lr_q, wd_q); // [R7] [R14]
    lout_d = int_d.left ? conv_q.data : lout_q; // [R14]
    rout_d = int_d.right ? conv_q.data : rout_q; // [R14]
    lcom_d = ctrl_q.single;
    if (ctrl_q.single) begin
      lout_d = `DSD_COMMON_CODE; // [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q <= '0;
      int_q <= '0;
      lout_q <= '0;
      rout_q <= '0;
      lcom_q <= 1'b0;
    end else begin
      conv_q <= conv_d;
      int_q <= int_d;
      lout_q <= lout_d;
      rout_q <= rout_d;
      lcom_q <= lcom_d;
    end
  end

  // ==========================================================
  // APB slave
  always_comb begin
    access = psel && penable && !pready_q;
    do_wr = psel && penable && pready_q && pwrite;
    status_clr = do_wr && (paddr == `DSD_STATUS_OFS);
    pready_d = access;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    ctrl_d = ctrl_q;
    if (access) begin
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (paddr == `DSD_CTRL_OFS) begin
        prdata_d[`DSD_CTRL_SINGLE_BIT] = ctrl_q.single;
        prdata_d[`DSD_CTRL_DEDICATE_BIT] = ctrl_q.dedicate;
      end else if (paddr == `DSD_STATUS_OFS) begin
        prdata_d[`DSD_STAT_OVF_BIT] = ovf_q;
        prdata_d[`DSD_STAT_RATE_BIT] = rate_q;
        prdata_d[`DSD_STAT_LEVEL_LSB +: `DSD_FIFO_AW+1] = fifo_level;
      end else if (paddr == `DSD_CONV_OFS) begin
        prdata_d[15:0] = conv_q.data;
        prdata_d[`DSD_CONV_CHAN_BIT] = conv_q.chan;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (do_wr && (paddr == `DSD_CTRL_OFS)) begin
      ctrl_d.single = pwdata[`DSD_CTRL_SINGLE_BIT]; // [R1]
      ctrl_d.dedicate = pwdata[`DSD_CTRL_DEDICATE_BIT]; // [R2]
    end
    // Hardware set wins over a software clear in the same cycle
    ovf_d = (ovf_q && !(status_clr && pwdata[`DSD_STAT_OVF_BIT]))
            || (push_valid && !push_ready);
    rate_d = (rate_q && !(status_clr && pwdata[`DSD_STAT_RATE_BIT]))
             || (bclk_rise && (32'(gap_q) + 1 < `DSD_BIT_MIN_CYC)); // [R10]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DSD_CTRL_RESET;
      ovf_q <= 1'b0;
      rate_q <= 1'b0;
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ovf_q <= ovf_d;
      rate_q <= rate_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign left_out = lout_q;
  assign right_out = rout_q;
  assign left_integrate = int_q.left;
  assign right_integrate = int_q.right;
  assign left_at_common = lcom_q;

  // ==========================================================
  // Checks
  msb_first_a: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    bclk_rise |=> shift_q[0] == $past(serial_data)
      && shift_q[15:1] == $past(shift_q[14:0]))
    else $error("serial shift not MSB first");

  load_last16_a: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    push_valid |-> bclk_rise && !word_latch_clock
      ##1 shift_q[15:1] == $past(push_data.data[14:0]))
    else $error("pushed word is not the last 16 bits");

  edge_only_a: assert property ( // [R9]
    @(posedge pclk) disable iff (!presetn)
    !bclk_rise |=> $stable(shift_q) && $stable(lr_q) && $stable(wd_q))
    else $error("serial state moved without bit-clock rise");

  two_chan_left_a: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    xfer_edge && !ctrl_q.single |-> push_valid
      && push_data.chan == dsd_chan_t'(lr_q))
    else $error("two-channel word steered wrongly");

  ded_left_a: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    xfer_edge && ctrl_q.single && !ctrl_q.dedicate |->
      push_valid == lr_q)
    else $error("left dedication acceptance wrong");

  ded_right_a: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    xfer_edge && ctrl_q.single && ctrl_q.dedicate |->
      push_valid == !lr_q)
    else $error("right dedication acceptance wrong");

  left_common_a: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    ctrl_q.single |=> left_out == `DSD_COMMON_CODE
      && !left_integrate && left_at_common)
    else $error("left output not parked in single mode");

  integ_decode_a: assert property ( // [R16]
    @(posedge pclk) disable iff (!presetn)
    !ctrl_q.single && lr_q && wd_q |=> right_integrate && !left_integrate)
    else $error("two-channel integrate decode wrong");

  hold_track_a: assert property ( // [R14]
    @(posedge pclk) disable iff (!presetn)
    right_integrate |-> right_out == $past(conv_q.data))
    else $error("integrating channel does not follow converter");

  conv_hold_a: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    !conv_load ##1 !conv_load |-> $stable(conv_q))
    else $error("converter register changed without a load");

  rate_flag_a: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    bclk_rise && gap_q == 2'h1 |=> rate_q)
    else $error("fast bit clock not flagged");

endmodule

// [hdl/dsd_map.svh]
`ifndef DSD_MAP_SVH
`define DSD_MAP_SVH

// ==========================================================
// Register offsets (byte addresses)
`define DSD_CTRL_OFS 8'h00
`define DSD_STATUS_OFS 8'h04
`define DSD_CONV_OFS 8'h08

// ==========================================================
// Field positions
`define DSD_CTRL_SINGLE_BIT 0
`define DSD_CTRL_DEDICATE_BIT 1
`define DSD_STAT_OVF_BIT 0
`define DSD_STAT_RATE_BIT 1
`define DSD_STAT_LEVEL_LSB 8
`define DSD_CONV_CHAN_BIT 16

// ==========================================================
// Reset values and codes
`define DSD_CTRL_RESET 2'h0
`define DSD_COMMON_CODE 16'h2e5b
`define DSD_WORD_BITS 16
`define DSD_FIFO_DEPTH 32
`define DSD_FIFO_AW 5

// ==========================================================
// Timing
`define DSD_PCLK_KHZ 25000
`define DSD_BCLK_MAX_KHZ 8470
`define DSD_BIT_MIN_CYC \
  ((`DSD_PCLK_KHZ + `DSD_BCLK_MAX_KHZ - 1) / `DSD_BCLK_MAX_KHZ)

`endif

// [hdl/dsd_pkg.sv]
package dsd_pkg;

  typedef enum logic {
    DSD_CH_RIGHT,
    DSD_CH_LEFT
  } dsd_chan_t;

  typedef struct packed {
    dsd_chan_t chan;
    logic [15:0] data;
  } dsd_word_t;

  typedef struct packed {
    logic dedicate;
    logic single;
  } dsd_ctrl_t;

  typedef struct packed {
    logic left;
    logic right;
  } dsd_pair_t;

endpackage

// [hdl/dsd_fifo.sv]
`timescale 1ns/1ns
module dsd_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] level
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] out_q, out_d;
  logic vld_q, vld_d;
  logic push, pop;

  // ==========================================================
  // Pointers, count and registered read stage
  always_comb begin
    push = in_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = (cnt_q != '0) && (!vld_q || out_ready);
    wptr_d = push ? wptr_q + 1'b1 : wptr_q;
    rptr_d = pop ? rptr_q + 1'b1 : rptr_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    out_d = pop ? mem_q[rptr_q] : out_q;
    vld_d = pop ? 1'b1 : (out_ready ? 1'b0 : vld_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      out_q <= '0;
      vld_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      vld_q <= vld_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = vld_q;
  assign out_data = out_q;
  assign level = cnt_q;

endmodule

// [bench/dsd_src.sv]
`timescale 1ns/1ns
module dsd_src (
  input wire logic pclk,
  output logic bit_clock,
  output logic serial_data,
  output logic word_latch_clock,
  output logic channel_select_clock
);
  // ==========================================================
  // Serial source
  int half = 2;
  initial begin
    {bit_clock, serial_data, word_latch_clock, channel_select_clock} = '0;
  end
  // One bit period, equal high and low, period 4 pclk by default
  task automatic tick(input logic d, input logic wd, input logic lr);
    serial_data <= d;
    word_latch_clock <= wd;
    channel_select_clock <= lr;
    repeat (half) @(posedge pclk);
    bit_clock <= 1'b1;
    repeat (half) @(posedge pclk);
    bit_clock <= 1'b0;
  endtask
  // Shifts n bits MSB first, then, if load is set, one rise with the word clock low
  // Back-to-back words stand in for the oversampled word rate
  task automatic word(input logic lr, input logic [19:0] d, input int n,
                      input bit load);
    @(posedge pclk);
    for (int i = n - 1; i >= 0; i--) begin
      tick(d[i], 1'b1, lr);
    end
    if (load) begin
      tick(~d[0], 1'b0, lr);
    end
    serial_data <= ~d[0];
  endtask
  // Word clock high with a fixed channel level: integrate window
  task automatic integ(input logic lr, input int n);
    @(posedge pclk);
    repeat (n) tick(~serial_data, 1'b1, lr);
  endtask
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ns
`include "dsd_map.svh"
module testbench;
  import dsd_pkg::*;
  `define CHK(n, e, a) chk(n, e, a)
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bclk, sdata, wclk, lrclk, conv_ready, err;
  logic [15:0] left_out, right_out;
  logic left_integrate, right_integrate, left_at_common;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  dsd_serial_dac_input dsd_serial_dac_input_i (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_clock(bclk), .serial_data(sdata),
    .word_latch_clock(wclk), .channel_select_clock(lrclk),
    .conv_ready(conv_ready), .left_out(left_out), .right_out(right_out),
    .left_integrate(left_integrate), .right_integrate(right_integrate),
    .left_at_common(left_at_common));
  dsd_src dsd_src_i (.pclk(pclk), .bit_clock(bclk), .serial_data(sdata),
    .word_latch_clock(wclk), .channel_select_clock(lrclk));
  // ==========================================================
  // Helpers
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] a);
    comparisons++;
    if (a !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, a);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_two();
    dsd_src_i.word(1'b0, 20'h0a5c3, 16, 1);
    dsd_src_i.integ(1'b1, 3);
    settle(1);
    `CHK("right_out", 16'ha5c3, right_out);
    apb(1'b0, `DSD_CONV_OFS, 32'h0);
    `CHK("conv", 17'h0a5c3, rd[16:0]);
    dsd_src_i.word(1'b1, 20'hf8001, 20, 1);
    dsd_src_i.integ(1'b0, 3);
    settle(1);
    `CHK("left_out", 16'h8001, left_out);
    `CHK("right_hold", 16'ha5c3, right_out);
    `CHK("integ", 2'h2, {left_integrate, right_integrate});
  endtask
  task automatic t_single();
    apb(1'b1, `DSD_CTRL_OFS, 32'h1);
    settle(2);
    `CHK("at_common", 1'b1, left_at_common);
    `CHK("left_common", 16'h2e5b, left_out);
    dsd_src_i.word(1'b0, 20'h01111, 16, 1);
    dsd_src_i.integ(1'b1, 3);
    settle(1);
    `CHK("drop_right", 16'h8001, right_out);
    dsd_src_i.word(1'b1, 20'h01234, 16, 1);
    dsd_src_i.integ(1'b1, 3);
    settle(1);
    `CHK("take_left", 16'h1234, right_out);
    `CHK("left_parked", 16'h2e5b, left_out);
    apb(1'b1, `DSD_CTRL_OFS, 32'h3);
    dsd_src_i.word(1'b0, 20'h05678, 16, 1);
    dsd_src_i.integ(1'b1, 3);
    settle(1);
    `CHK("take_right", 16'h5678, right_out);
    dsd_src_i.word(1'b1, 20'h09abc, 16, 1);
    dsd_src_i.integ(1'b1, 3);
    settle(1);
    `CHK("drop_left", 16'h5678, right_out);
    apb(1'b1, `DSD_CTRL_OFS, 32'h0);
  endtask
  task automatic t_stop();
    dsd_src_i.word(1'b0, 20'h00f0f, 16, 0);
    apb(1'b0, `DSD_CONV_OFS, 32'h0);
    `CHK("no_load", 16'h5678, rd[15:0]);
    @(posedge pclk);
    dsd_src_i.tick(1'b1, 1'b0, 1'b0);
    settle(4);
    apb(1'b0, `DSD_CONV_OFS, 32'h0);
    `CHK("late_load", 17'h00f0f, rd[16:0]);
  endtask
  task automatic t_fifo();
    @(posedge pclk);
    conv_ready <= 1'b0;
    for (int i = 0; i < 34; i++) dsd_src_i.word(1'b0, 20'(i), 16, 1);
    apb(1'b0, `DSD_STATUS_OFS, 32'h0);
    `CHK("full", 7'h41, {rd[13:8], rd[0]});
    dsd_src_i.half = 1;
    dsd_src_i.integ(1'b0, 3);
    dsd_src_i.half = 2;
    apb(1'b0, `DSD_STATUS_OFS, 32'h0);
    `CHK("rate", 1'b1, rd[1]);
    apb(1'b1, `DSD_STATUS_OFS, 32'h3);
    conv_ready <= 1'b1;
    settle(100);
    apb(1'b0, `DSD_STATUS_OFS, 32'h0);
    `CHK("drained", 32'h0, rd);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    conv_ready = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `DSD_CTRL_OFS, 32'h0);
    `CHK("ctrl_rst", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0);
    `CHK("unmapped_err", 1'b1, err);
    `CHK("unmapped_rd", 32'h0, rd);
    `CHK("common_rst", 1'b0, left_at_common);
    $display("test reset done");
    t_two();
    $display("test two_channel done");
    t_single();
    $display("test single done");
    t_stop();
    $display("test stopped_clock done");
    t_fifo();
    $display("test fifo done");
    finish_test();
  end
endmodule
